//--- csc_pkg.sv
// Constants, types and helpers shared by the CPU status and clock control block
// Overview of operation
// - Two-bit source field picks PLL, main oscillator, slow oscillator, or no clock.
// - Four-bit divisor code maps to fixed divisors; code 1111 stops the core clock.
// - Speed bit 7 low runs the fifty-times PLL, high shuts it down.
// - Speed bit 6 high stops the main oscillator and blocks its external input.
// - Active speed changes only by speed instruction, interrupt entry or interrupt return.
// - Interrupt entry copies the interrupt speed setting into the active speed setting.
// - Null flag is set on zero result of affected instructions, else cleared.
// - Nibble flag: add carry from bit 3 sets; subtract borrow from bit 3 clears.
// - Byte flag: add carry from bit 7 sets; subtract borrow from bit 7 clears.
// - Rotate right loads byte flag with operand bit 0, rotate left with bit 7.
// - Page bits extend the 13-bit jump target; set by the page instruction.
// - Plain return enters skipping when skip-after-return is set, then clears it.
// - Shadowed skip flag records interrupt taken right after a skip; software may clear.
// - Multiply puts product high byte in its register and low byte in accumulator.
// - Divisor only slows the core; peripherals keep the undivided system clock.
package csc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] OFS_FLAGS  = 4'h0;
  localparam logic [3:0] OFS_ACTIVE = 4'h1;
  localparam logic [3:0] OFS_ISR    = 4'h2;
  localparam logic [3:0] OFS_PRODH  = 4'h3;
  localparam logic [3:0] OFS_EXTRA  = 4'h4;

  // ==========================================================
  // Field positions
  localparam int BIT_C      = 0;
  localparam int BIT_NIB    = 1;
  localparam int BIT_Z      = 2;
  localparam int BIT_SHSKIP = 3;
  localparam int BIT_SKRET  = 4;
  localparam int PA_LO      = 5;
  localparam int SPD_DIV_LO = 0;
  localparam int SPD_SRC_LO = 4;
  localparam int SPD_OSC    = 6;
  localparam int SPD_PLL    = 7;

  // ==========================================================
  // Encodings and reset values
  localparam logic [1:0] SRC_PLL  = 2'h0;
  localparam logic [1:0] SRC_OSC  = 2'h1;
  localparam logic [1:0] SRC_SLOW = 2'h2;
  localparam logic [1:0] SRC_OFF  = 2'h3;
  localparam logic [3:0] DIV_OFF  = 4'hF;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] SPEED_RST = 8'h00;
  localparam logic [7:0] ISR_RST   = 8'h00;
  localparam logic [7:0] EXTRA_RST = 8'h00;
  localparam logic [7:0] PRODH_RST = 8'h00;
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [15:0] JUMP_RST = 16'h0000;
  localparam int SWITCH_MAX_CYC    = 130;

  typedef enum logic [2:0] {
    CSC_OP_NONE = 3'h0, CSC_OP_LOAD = 3'h1, CSC_OP_ADD = 3'h2, CSC_OP_SUB = 3'h3,
    CSC_OP_ROR  = 3'h4, CSC_OP_ROL  = 3'h5, CSC_OP_MULU = 3'h6, CSC_OP_MULS = 3'h7
  } csc_alu_op_e;

  typedef enum logic [1:0] {
    CSC_ST_RUN    = 2'b01,
    CSC_ST_SWITCH = 2'b10
  } csc_sw_e;

  // Divisor for a code; zero means core clock off
  function automatic logic [7:0] csc_div_of(input logic [3:0] code);
    logic [7:0] d;
    d = 8'h00;
    unique case (code)
      4'h0: d = 8'h01;
      4'h1: d = 8'h02;
      4'h2: d = 8'h03;
      4'h3: d = 8'h04;
      4'h4: d = 8'h05;
      4'h5: d = 8'h06;
      4'h6: d = 8'h08;
      4'h7: d = 8'h0A;
      4'h8: d = 8'h0C;
      4'h9: d = 8'h10;
      4'hA: d = 8'h18;
      4'hB: d = 8'h20;
      4'hC: d = 8'h30;
      4'hD: d = 8'h40;
      4'hE: d = 8'h80;
      4'hF: d = 8'h00;
    endcase
    return d;
  endfunction

endpackage

//--- csc_alu_if.sv
// Bundle between the flag logic and its arithmetic unit
`timescale 1ns/1ps
interface csc_alu_if;
  import csc_pkg::*;
  csc_alu_op_e op;
  logic [7:0]  a;
  logic [7:0]  b;
  logic        c_in;
  logic [7:0]  result;
  logic [7:0]  prod_high;
  logic        c;
  logic        nib;
  logic        z;
  logic        upd_c;
  logic        upd_nib;
  logic        upd_z;
  modport unit (input op, a, b, c_in,
                output result, prod_high, c, nib, z, upd_c, upd_nib, upd_z);
  modport core (output op, a, b, c_in,
                input result, prod_high, c, nib, z, upd_c, upd_nib, upd_z);
endinterface

//--- csc_alu_unit.sv
// Arithmetic unit producing results and condition flags
`timescale 1ns/1ps
module csc_alu_unit
  import csc_pkg::*;
(
  csc_alu_if.unit bus
);
  logic [8:0]  sum9;
  logic [4:0]  nib5;
  logic [15:0] prod;

  // ==========================================================
  // Result and flag generation
  always_comb begin
    sum9 = {1'b0, bus.a} + {1'b0, bus.b};
    nib5 = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
    prod = 16'h0000;
    bus.result = 8'h00;
    bus.c = 1'b0;
    bus.nib = 1'b0;
    bus.upd_c = 1'b0;
    bus.upd_nib = 1'b0;
    bus.upd_z = 1'b0;
    unique case (bus.op)
      CSC_OP_NONE: begin
      end
      CSC_OP_LOAD: begin
        bus.result = bus.b;
        bus.upd_z = 1'b1;
      end
      CSC_OP_ADD: begin
        bus.result = sum9[7:0];
        bus.c = sum9[8];
        bus.nib = nib5[4];
        {bus.upd_c, bus.upd_nib, bus.upd_z} = 3'h7;
      end
      CSC_OP_SUB: begin
        bus.result = bus.a - bus.b;
        bus.c = (bus.a >= bus.b);
        bus.nib = (bus.a[3:0] >= bus.b[3:0]);
        {bus.upd_c, bus.upd_nib, bus.upd_z} = 3'h7;
      end
      CSC_OP_ROR: begin
        bus.result = {bus.c_in, bus.a[7:1]};
        bus.c = bus.a[0];
        bus.upd_c = 1'b1;
      end
      CSC_OP_ROL: begin
        bus.result = {bus.a[6:0], bus.c_in};
        bus.c = bus.a[7];
        bus.upd_c = 1'b1;
      end
      CSC_OP_MULU: begin
        prod = bus.a * bus.b;
        bus.result = prod[7:0];
      end
      CSC_OP_MULS: begin
        prod = 16'($signed(bus.a) * $signed(bus.b));
        bus.result = prod[7:0];
      end
    endcase
    bus.prod_high = prod[15:8];
    bus.z = (bus.result == 8'h00);
  end
endmodule

//--- csc_core_div.sv
// Core clock divider giving one enable pulse per divided period
`timescale 1ns/1ps
module csc_core_div
  import csc_pkg::*;
#(
  parameter int CNT_W = 7
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] div_code_i,
  input  wire logic       run_i,
  output logic            tick_o,
  output logic            boundary_o
);
  logic [CNT_W-1:0] cnt;
  logic [7:0]       div;
  logic             off;

  // ==========================================================
  // Terminal count and boundary
  assign div        = csc_div_of(div_code_i);
  assign off        = (div == 8'h00) || !run_i;
  assign tick_o     = !off && (cnt == CNT_W'(div - 8'h01));
  assign boundary_o = tick_o || off;

  // Period counter, restarts at each boundary
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || off || tick_o) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule

//--- csc_top.sv
// CPU status flags, product register and clock speed control
`timescale 1ns/1ps
module csc_top
  import csc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        speed_exec_i,
  input  wire logic [7:0]  speed_val_i,
  input  wire logic        irq_take_i,
  input  wire logic [2:0]  irq_page_i,
  input  wire logic        skipping_i,
  input  wire logic        reti_i,
  input  wire logic        ret_plain_i,
  input  wire logic        page_exec_i,
  input  wire logic [2:0]  page_val_i,
  input  wire logic        jump_exec_i,
  input  wire logic [12:0] jump_target_i,
  output logic      [15:0] jump_addr_o,
  input  wire csc_alu_op_e alu_op_i,
  input  wire logic [7:0]  alu_a_i,
  input  wire logic [7:0]  alu_b_i,
  output logic      [7:0]  acc_o,
  output logic      [7:0]  flags_o,
  output logic             skip_after_ret_o,
  output logic      [2:0]  page_select_o,
  output logic             pll_run_o,
  output logic             osc_run_o,
  output logic             osc_ext_pass_o,
  output logic      [1:0]  sys_src_o,
  output logic             sys_clk_on_o,
  output logic             core_en_o,
  output logic             periph_en_o,
  output logic             switch_busy_o
);

  // ==========================================================
  // Internal state
  logic [7:0] flags;
  logic [7:0] flags_shadow;
  logic [7:0] prod_high;
  logic [7:0] active_spd;
  logic [7:0] saved_spd;
  logic [7:0] isr_spd;
  logic [7:0] applied_spd;
  logic [7:0] extra_cfg;
  csc_sw_e    sw_state;
  logic       tick;
  logic       boundary;
  logic       hw_flags;
  logic [1:0] app_src;

  // Bound of the switch check, kept local for the delay range
  localparam int SW_BOUND = SWITCH_MAX_CYC;

  csc_alu_if alu_bus ();

  // ==========================================================
  // Arithmetic unit connection
  assign alu_bus.op   = alu_op_i;
  assign alu_bus.a    = alu_a_i;
  assign alu_bus.b    = alu_b_i;
  assign alu_bus.c_in = flags[BIT_C];

  csc_alu_unit csc_alu_unit_i (
    .bus (alu_bus)
  );

  // ==========================================================
  // Condition and page flags; hardware updates win over a bus write
  assign hw_flags = reti_i || irq_take_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags <= FLAGS_RST;
    end else begin
      if (reg_we_i && reg_addr_i == OFS_FLAGS) begin
        flags <= reg_wdata_i;
      end
      if (reti_i) begin
        flags <= flags_shadow;
      end else if (irq_take_i) begin
        flags[PA_LO +: 3] <= irq_page_i;
        flags[BIT_SHSKIP] <= skipping_i;
      end else begin
        if (alu_bus.upd_c) begin
          flags[BIT_C] <= alu_bus.c;
        end
        if (alu_bus.upd_nib) begin
          flags[BIT_NIB] <= alu_bus.nib;
        end
        if (alu_bus.upd_z) begin
          flags[BIT_Z] <= alu_bus.z;
        end
        if (page_exec_i) begin
          flags[PA_LO +: 3] <= page_val_i;
        end
        if (ret_plain_i) begin
          flags[BIT_SKRET] <= 1'b0;
        end
      end
    end
  end

  // Copy of the flags taken on interrupt entry
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags_shadow <= FLAGS_RST;
    end else if (irq_take_i) begin
      flags_shadow <= flags;
    end
  end

  assign flags_o       = flags;
  assign page_select_o = flags[PA_LO +: 3];

  // ==========================================================
  // Jump target extension and skip after return
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      jump_addr_o <= JUMP_RST;
    end else if (jump_exec_i) begin
      jump_addr_o <= {flags[PA_LO +: 3], jump_target_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      skip_after_ret_o <= 1'b0;
    end else begin
      skip_after_ret_o <= ret_plain_i && !hw_flags && flags[BIT_SKRET];
    end
  end

  // ==========================================================
  // Accumulator and product high byte
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc_o <= ACC_RST;
    end else if (alu_op_i != CSC_OP_NONE) begin
      acc_o <= alu_bus.result;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prod_high <= PRODH_RST;
    end else if (alu_op_i == CSC_OP_MULU || alu_op_i == CSC_OP_MULS) begin
      prod_high <= alu_bus.prod_high;
    end
  end

  // ==========================================================
  // Speed settings; the active one ignores bus writes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      active_spd <= SPEED_RST;
    end else if (reti_i) begin
      active_spd <= saved_spd;
    end else if (irq_take_i) begin
      active_spd <= isr_spd;
    end else if (speed_exec_i) begin
      active_spd <= speed_val_i;
    end
  end

  // Setting in force before the interrupt, restored on return
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      saved_spd <= SPEED_RST;
    end else if (irq_take_i && !reti_i) begin
      saved_spd <= active_spd;
    end
  end

  // Software-owned interrupt speed and extra configuration
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      isr_spd   <= ISR_RST;
      extra_cfg <= EXTRA_RST;
    end else if (reg_we_i) begin
      if (reg_addr_i == OFS_ISR) begin
        isr_spd <= reg_wdata_i;
      end
      if (reg_addr_i == OFS_EXTRA) begin
        extra_cfg <= reg_wdata_i;
      end
    end
  end

  // ==========================================================
  // Clean switch: new setting applied only at a core boundary
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sw_state    <= CSC_ST_RUN;
      applied_spd <= SPEED_RST;
    end else begin
      unique case (sw_state)
        CSC_ST_RUN: begin
          if (active_spd != applied_spd) begin
            sw_state <= CSC_ST_SWITCH;
          end
        end
        CSC_ST_SWITCH: begin
          if (boundary) begin
            applied_spd <= active_spd;
            sw_state    <= CSC_ST_RUN;
          end
        end
        default: begin
          sw_state <= CSC_ST_RUN;
        end
      endcase
    end
  end

  assign switch_busy_o = (sw_state == CSC_ST_SWITCH);

  // ==========================================================
  // Clock source, oscillator and PLL controls
  assign app_src        = applied_spd[SPD_SRC_LO +: 2];
  assign pll_run_o      = !applied_spd[SPD_PLL];
  assign osc_run_o      = !applied_spd[SPD_OSC];
  assign osc_ext_pass_o = !applied_spd[SPD_OSC];
  assign sys_src_o      = app_src;
  assign sys_clk_on_o   = (app_src == SRC_PLL && pll_run_o) ||
                          (app_src == SRC_OSC && osc_run_o) ||
                          (app_src == SRC_SLOW);
  assign periph_en_o    = sys_clk_on_o;

  csc_core_div #(
    .CNT_W (7)
  ) csc_core_div_i (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .div_code_i (applied_spd[SPD_DIV_LO +: 4]),
    .run_i      (sys_clk_on_o),
    .tick_o     (tick),
    .boundary_o (boundary)
  );

  assign core_en_o = tick;

  // ==========================================================
  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !reg_re_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      unique case (reg_addr_i)
        OFS_FLAGS:  reg_rdata_o <= flags;
        OFS_ACTIVE: reg_rdata_o <= active_spd;
        OFS_ISR:    reg_rdata_o <= isr_spd;
        OFS_PRODH:  reg_rdata_o <= prod_high;
        OFS_EXTRA:  reg_rdata_o <= extra_cfg;
        default:    reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Checks
  a_src_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sys_src_o == SRC_OFF) |-> !sys_clk_on_o && !periph_en_o && !core_en_o)
    else $error("core or peripherals clocked with source off");

  a_div_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (applied_spd[SPD_DIV_LO +: 4] == DIV_OFF) |-> !core_en_o)
    else $error("core enable pulsed with divisor off");

  a_div_two: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (core_en_o && applied_spd[SPD_DIV_LO +: 4] == 4'h1 && sys_clk_on_o
     && $stable(applied_spd)) |=> !core_en_o)
    else $error("divide by two ticked twice in a row");

  a_pll_ctrl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(pll_run_o) |-> $past(active_spd[SPD_PLL]) && $past(switch_busy_o))
    else $error("PLL stopped without a setting asking for it");

  a_osc_ctrl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(osc_run_o) |-> osc_run_o == !$past(active_spd[SPD_OSC])
    && osc_ext_pass_o == osc_run_o)
    else $error("oscillator control not from the active setting");

  a_spd_readonly: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!speed_exec_i && !irq_take_i && !reti_i) |=> $stable(active_spd))
    else $error("active speed changed without an allowed event");

  a_irq_copy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_take_i && !reti_i) |=> active_spd == $past(isr_spd))
    else $error("interrupt speed not copied on interrupt entry");

  a_null_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (alu_bus.upd_z && !hw_flags) |=> flags[BIT_Z] == ($past(alu_bus.result) == 8'h00))
    else $error("null flag does not match result");

  a_nibble_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (alu_op_i == CSC_OP_ADD && !hw_flags)
    |=> flags[BIT_NIB] == (({1'b0, $past(alu_a_i[3:0])} + {1'b0, $past(alu_b_i[3:0])}) > 5'h0F))
    else $error("nibble flag wrong after addition");

  a_byte_borrow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (alu_op_i == CSC_OP_SUB && !hw_flags)
    |=> flags[BIT_C] == ($past(alu_a_i) >= $past(alu_b_i)))
    else $error("byte flag wrong after subtraction");

  a_rotate_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (alu_op_i == CSC_OP_ROR && !hw_flags) |=> flags[BIT_C] == $past(alu_a_i[0]))
    else $error("rotate right did not load bit 0");

  a_page_jump: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (page_exec_i && !hw_flags) ##1 (jump_exec_i && !hw_flags)
    |=> jump_addr_o == {$past(page_val_i, 2), $past(jump_target_i)})
    else $error("jump address not extended by page bits");

  a_ret_skip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ret_plain_i && !hw_flags) |=> skip_after_ret_o == $past(flags[BIT_SKRET])
    && !flags[BIT_SKRET])
    else $error("skip after return mishandled");

  a_skip_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_take_i && !reti_i) |=> flags[BIT_SHSKIP] == $past(skipping_i))
    else $error("shadowed skip flag not captured");

  a_mul_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (alu_op_i == CSC_OP_MULU) |=> {prod_high, acc_o} == $past(alu_a_i) * $past(alu_b_i))
    else $error("unsigned product misplaced");

  a_periph_free: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sys_clk_on_o && applied_spd[SPD_DIV_LO +: 4] != 4'h0) |-> periph_en_o)
    else $error("peripherals slowed by core divisor");

  a_clean_switch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(applied_spd) |-> $past(switch_busy_o) && $past(boundary))
    else $error("setting applied away from a core boundary");

  a_switch_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(switch_busy_o) |-> ##[1:SW_BOUND] !switch_busy_o)
    else $error("setting switch did not complete in time");

endmodule

//--- csc_top_tb.sv
// Self-checking testbench for the CPU status and clock control block
`timescale 1ns/1ps
module csc_top_tb;
  import csc_pkg::*;
  logic        clk_i, rst_n_i, reg_we_i, reg_re_i, speed_exec_i, irq_take_i;
  logic        skipping_i, reti_i, ret_plain_i, page_exec_i, jump_exec_i;
  logic [3:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, speed_val_i, alu_a_i, alu_b_i, reg_rdata_o, acc_o, flags_o, d;
  logic [2:0]  irq_page_i, page_val_i, page_select_o;
  logic [12:0] jump_target_i;
  logic [15:0] jump_addr_o;
  csc_alu_op_e alu_op_i;
  logic        skip_after_ret_o, pll_run_o, osc_run_o, osc_ext_pass_o, sys_clk_on_o;
  logic        core_en_o, periph_en_o, switch_busy_o;
  logic [1:0]  sys_src_o;
  int          n_fail, n_compared;

  // ==========================================================
  // Device under test and clock
  csc_top csc_top_i (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
    .reg_rdata_o, .speed_exec_i, .speed_val_i, .irq_take_i, .irq_page_i, .skipping_i,
    .reti_i, .ret_plain_i, .page_exec_i, .page_val_i, .jump_exec_i, .jump_target_i,
    .jump_addr_o, .alu_op_i, .alu_a_i, .alu_b_i, .acc_o, .flags_o, .skip_after_ret_o,
    .page_select_o, .pll_run_o, .osc_run_o, .osc_ext_pass_o, .sys_src_o, .sys_clk_on_o,
    .core_en_o, .periph_en_o, .switch_busy_o);

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Register write and read, one strobe cycle each
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask

  // Bounded wait until a pending speed setting is applied
  task automatic wait_idle();
    repeat (3) @(posedge clk_i);
    #1;
    for (int i = 0; i < 300 && switch_busy_o !== 1'b0; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (switch_busy_o !== 1'b0) begin
      n_fail++;
      print_verdict();
    end
  endtask

  // Speed instruction, then check the applied setting
  task automatic spd(input logic [7:0] v);
    @(posedge clk_i);
    speed_exec_i <= 1'b1;
    speed_val_i  <= v;
    @(posedge clk_i);
    speed_exec_i <= 1'b0;
    wait_idle();
    rd(OFS_ACTIVE, d);
    chk("active", d, v);
    chk("source", sys_src_o, v[5:4]);
    chk("pll run", pll_run_o, !v[7]);
    chk("osc run", {osc_run_o, osc_ext_pass_o}, {2{!v[6]}});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reg();
    for (int k = 0; k < 6; k++) begin
      rd(k[3:0], d);
      chk("reset value", d, 8'h00);
    end
    wr(OFS_ISR, 8'h51);
    wr(OFS_ACTIVE, 8'hFF);
    rd(OFS_ISR, d);
    chk("isr speed", d, 8'h51);
    rd(OFS_ACTIVE, d);
    chk("active ro", d, 8'h00);
    $display("end of register test");
  endtask

  task automatic t_alu();
    csc_alu_op_e op [9] = '{CSC_OP_ADD, CSC_OP_ADD, CSC_OP_SUB, CSC_OP_SUB, CSC_OP_ROR,
                            CSC_OP_ROL, CSC_OP_LOAD, CSC_OP_MULU, CSC_OP_MULS};
    logic [7:0] a [9] = '{8'h0F, 8'hFF, 8'h10, 8'h01, 8'h01, 8'h7F, 8'h00, 8'h10, 8'hFF};
    logic [7:0] b [9] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h20, 8'h02};
    logic [7:0] ea [9] = '{8'h10, 8'h00, 8'h0F, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFE};
    logic [7:0] eh [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'hFF};
    logic [2:0] ef [9] = '{3'h2, 3'h7, 3'h1, 3'h0, 3'h1, 3'h0, 3'h4, 3'h0, 3'h0};
    foreach (op[k]) begin
      @(posedge clk_i);
      alu_op_i <= op[k];
      alu_a_i  <= a[k];
      alu_b_i  <= b[k];
      @(posedge clk_i);
      alu_op_i <= CSC_OP_NONE;
      #1;
      chk("acc", acc_o, ea[k]);
      if (k < 7) chk("flags", flags_o[2:0], ef[k]);
      else begin
        rd(OFS_PRODH, d);
        chk("product high", d, eh[k]);
      end
    end
    wr(OFS_PRODH, 8'h55);
    rd(OFS_PRODH, d);
    chk("product high ro", d, 8'hFF);
    $display("end of arithmetic test");
  endtask

  task automatic t_div();
    logic [3:0] code [6] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'hE, 4'hF};
    logic [15:0] exp [6] = '{16'h0180, 16'h00C0, 16'h0080, 16'h0030, 16'h0003, 16'h0000};
    logic [15:0] c, p;
    foreach (code[k]) begin
      spd({4'h0, code[k]});
      c = 16'h0000;
      p = 16'h0000;
      repeat (384) begin
        @(posedge clk_i);
        #1;
        c += {15'h0000, core_en_o === 1'b1};
        p += {15'h0000, periph_en_o === 1'b1};
      end
      chk("core ticks", c, exp[k]);
      chk("periph ticks", p, 16'h0180);
    end
    $display("end of divisor test");
  endtask

  task automatic t_src();
    logic [7:0] v [5] = '{8'h80, 8'h50, 8'h30, 8'h10, 8'h00};
    logic on [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    foreach (v[k]) begin
      spd(v[k]);
      chk("clock on", sys_clk_on_o, on[k]);
      chk("periph on", periph_en_o, on[k]);
    end
    $display("end of source test");
  endtask

  task automatic t_irq();
    wr(OFS_ISR, 8'hE0);
    @(posedge clk_i);
    irq_take_i <= 1'b1;
    skipping_i <= 1'b1;
    irq_page_i <= 3'h6;
    @(posedge clk_i);
    irq_take_i <= 1'b0;
    skipping_i <= 1'b0;
    wait_idle();
    rd(OFS_ACTIVE, d);
    chk("irq active", d, 8'hE0);
    chk("irq source", {sys_src_o, pll_run_o, osc_run_o}, 4'h8);
    chk("skip shadow", flags_o[3], 1'b1);
    chk("irq page", page_select_o, 3'h6);
    @(posedge clk_i);
    reti_i <= 1'b1;
    @(posedge clk_i);
    reti_i <= 1'b0;
    wait_idle();
    rd(OFS_ACTIVE, d);
    chk("reti active", d, 8'h00);
    chk("reti shadow", flags_o[3], 1'b0);
    $display("end of interrupt test");
  endtask

  task automatic t_page();
    @(posedge clk_i);
    page_exec_i <= 1'b1;
    page_val_i  <= 3'h5;
    @(posedge clk_i);
    page_exec_i   <= 1'b0;
    jump_exec_i   <= 1'b1;
    jump_target_i <= 13'h1ABC;
    @(posedge clk_i);
    jump_exec_i <= 1'b0;
    #1;
    chk("page", page_select_o, 3'h5);
    chk("jump", jump_addr_o, {3'h5, 13'h1ABC});
    wr(OFS_FLAGS, 8'h10);
    @(posedge clk_i);
    ret_plain_i <= 1'b1;
    @(posedge clk_i);
    ret_plain_i <= 1'b0;
    #1;
    chk("skip pulse", skip_after_ret_o, 1'b1);
    chk("skip bit cleared", flags_o[4], 1'b0);
    @(posedge clk_i);
    #1;
    chk("skip pulse end", skip_after_ret_o, 1'b0);
    $display("end of page and return test");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {reg_we_i, reg_re_i, speed_exec_i, irq_take_i, skipping_i, reti_i} = '0;
    {ret_plain_i, page_exec_i, jump_exec_i, reg_addr_i, reg_wdata_i} = '0;
    {speed_val_i, alu_a_i, alu_b_i, irq_page_i, page_val_i, jump_target_i} = '0;
    alu_op_i = CSC_OP_NONE;
    n_fail = 0;
    n_compared = 0;
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reg();
    t_alu();
    t_div();
    t_src();
    t_irq();
    t_page();
    print_verdict();
  end
endmodule
